//--- logic/cbmrp_defines.vh
// Constants for the core bus master read port: widths, codes and reset values.
// Assumes inclusion by bare name from the lane selector, the read port and the memory model.
`ifndef CBMRP_DEFINES_VH
`define CBMRP_DEFINES_VH

// ****************************************
// Bus widths
// ****************************************
`define CBMRP_ADDR_W 23
`define CBMRP_DATA_W 32
`define CBMRP_SIZE_W 2
`define CBMRP_CODE_W 3
`define CBMRP_WAIT_W 8

// ****************************************
// Transfer size codes
// ****************************************
`define CBMRP_SIZE_WORD 2'h0
`define CBMRP_SIZE_BYTE 2'h1
`define CBMRP_SIZE_HALF 2'h2

// ****************************************
// Response buffer
// ****************************************
`define CBMRP_FIFO_DEPTH 4
`define CBMRP_FIFO_AW 2
`define CBMRP_FIFO_CW 3
`define CBMRP_RSP_W 42
// Highest count of stored, in-flight and pending results that still leaves a slot for one more
`define CBMRP_ISSUE_MAX_FILL 3'h3
`define CBMRP_WAIT_MAX 8'hFF

// ****************************************
// Reset values
// ****************************************
`define CBMRP_RST_ADDR 23'h000000
`define CBMRP_RST_SIZE 2'h0
`define CBMRP_RST_CODE 3'h0

`endif

//--- logic/cbmrp_fifo.v
// Response buffer: synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module cbmrp_fifo #(
  parameter WIDTH = 42,
  parameter DEPTH = 4,
  parameter AW = 2,
  parameter CW = 3
) (
  input wire ref_clk,
  input wire arst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [CW-1:0] level
);

  // ****************************************
  // Storage and pointers
  // ****************************************
  localparam [CW-1:0] FULL_LEVEL = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [CW-1:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != FULL_LEVEL);
  assign out_valid = (count_reg != {CW{1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_reg];
  assign level = count_reg;

  // Storage words carry no reset; only the count defines emptiness
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {CW{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // cbmrp_fifo

`default_nettype wire

//--- logic/cbmrp_lane_mux.v
// Read lane selector: maps the bus lanes of a sized read onto a right-justified operand.
// Assumes size and offset are those captured when the access was accepted.
`timescale 1ns/1ps
`default_nettype none
`include "cbmrp_defines.vh"

module cbmrp_lane_mux (
  input wire [`CBMRP_SIZE_W-1:0] xfer_size,
  input wire [1:0] byte_offset,
  input wire [`CBMRP_DATA_W-1:0] bus_data,
  output reg [`CBMRP_DATA_W-1:0] operand,
  output reg [1:0] first_mux_byte
);

  // ****************************************
  // Lane routing
  // ****************************************
  // Narrow reads always land on the low lanes, so the offset only names the mux byte
  always @* begin
    case (xfer_size)
      `CBMRP_SIZE_BYTE: begin
        operand = {24'h000000, bus_data[7:0]};
        first_mux_byte = byte_offset;
      end
      `CBMRP_SIZE_HALF: begin
        operand = {16'h0000, bus_data[15:0]};
        first_mux_byte = {byte_offset[1], 1'b0};
      end
      `CBMRP_SIZE_WORD: begin
        operand = bus_data;
        first_mux_byte = 2'h0;
      end
      default: begin
        // Unused size code: treated as a full word
        operand = bus_data;
        first_mux_byte = 2'h0;
      end
    endcase
  end

endmodule // cbmrp_lane_mux

`default_nettype wire

//--- logic/cbmrp_read_port.v
// Core bus master read port: issues overlapped read requests and collects terminations.
// Assumes the far interface logic acknowledges or errors each access synchronously.
//
// Contract
// - Separate 23-bit address and 32-bit data buses on every transfer.
// - Byte read: low lane carries mux byte selected by low address bits.
// - Half-word read: two low lanes carry mux bytes 0,1 or 2,3.
// - Word read: mux bytes 0..3 fill lanes high to low.
// - Unused lanes are ignored on reads.
// - Interrupt request inputs are sampled on the rising edge.
// - An unaccepted request may be replaced by a newer one.
// - Request accepted when idle, or when in-flight access terminates that cycle.
// - Abort may assert in the cycle after an accepted request.
// - Request state drives address, type code, size, read high, request.
// - Access-in-flight indicator asserts while the access takes place.
// - Acknowledge sampled each edge; data latched on it, else wait state.
// - Completion state carries next request or idle lines.
// - Back-to-back: completion of one coincides with request of next.
// - Error terminates regardless of acknowledge; neither means wait.
`timescale 1ns/1ps
`default_nettype none
`include "cbmrp_defines.vh"

module cbmrp_read_port (
  input wire ref_clk,
  input wire arst_n,
  // Core side request
  input wire req_valid,
  output wire req_ready,
  input wire [`CBMRP_ADDR_W-1:0] req_addr,
  input wire [`CBMRP_SIZE_W-1:0] req_size,
  input wire [`CBMRP_CODE_W-1:0] req_code,
  input wire req_abort,
  output wire req_replaced,
  // Core side response
  output wire rsp_valid,
  input wire rsp_ready,
  output wire [`CBMRP_DATA_W-1:0] rsp_data,
  output wire rsp_error,
  output wire rsp_aborted,
  output wire [`CBMRP_WAIT_W-1:0] rsp_wait,
  // Bus pins
  output wire [`CBMRP_ADDR_W-1:0] addr,
  input wire [`CBMRP_DATA_W-1:0] data_in,
  output wire [`CBMRP_DATA_W-1:0] data_out,
  output wire data_oe_n,
  output wire [`CBMRP_SIZE_W-1:0] xfer_size,
  output wire [`CBMRP_CODE_W-1:0] access_type_code,
  output wire read_write,
  output wire xfer_request_n,
  output wire access_in_flight,
  output wire abort,
  input wire xfer_done_n,
  input wire xfer_error_n,
  // Interrupt requests
  input wire irq_n,
  input wire fast_irq_n,
  output wire irq_seen_n,
  output wire fast_irq_seen_n
);

  // ****************************************
  // State
  // ****************************************
  reg pend_reg;
  reg pend_next;
  reg [`CBMRP_ADDR_W-1:0] addr_reg;
  reg [`CBMRP_ADDR_W-1:0] addr_next;
  reg [`CBMRP_SIZE_W-1:0] size_reg;
  reg [`CBMRP_SIZE_W-1:0] size_next;
  reg [`CBMRP_CODE_W-1:0] code_reg;
  reg [`CBMRP_CODE_W-1:0] code_next;
  reg pend_abort_reg;
  reg pend_abort_next;
  reg busy_reg;
  reg busy_next;
  reg [`CBMRP_SIZE_W-1:0] fl_size_reg;
  reg [`CBMRP_SIZE_W-1:0] fl_size_next;
  reg [1:0] fl_off_reg;
  reg [1:0] fl_off_next;
  reg fl_abort_reg;
  reg fl_abort_next;
  reg abort_reg;
  reg abort_next;
  reg [`CBMRP_WAIT_W-1:0] wait_reg;
  reg [`CBMRP_WAIT_W-1:0] wait_next;
  reg replaced_reg;
  reg replaced_next;
  reg irq_reg;
  reg fast_irq_reg;

  wire term;
  wire term_error;
  wire accept;
  wire load;
  wire fifo_in_ready;
  wire [`CBMRP_FIFO_CW-1:0] fifo_level;
  wire [`CBMRP_FIFO_CW-1:0] outstanding;
  wire [`CBMRP_DATA_W-1:0] operand;
  wire [`CBMRP_RSP_W-1:0] rsp_word;
  wire [`CBMRP_RSP_W-1:0] fifo_out;

  // ****************************************
  // Termination and acceptance
  // ****************************************
  // Error takes priority: an aborted or faulted access ends as an error even with acknowledge
  assign term_error = busy_reg & ~xfer_error_n;
  assign term = busy_reg & (~xfer_error_n | ~xfer_done_n);
  assign accept = pend_reg & (~busy_reg | term);

  // Count stored, in-flight and pending results, so a terminating access is never refused a slot
  assign outstanding = fifo_level + {2'h0, busy_reg} + {2'h0, pend_reg};
  assign req_ready = fifo_in_ready & (outstanding <= `CBMRP_ISSUE_MAX_FILL);
  assign load = req_valid & req_ready;
  assign req_replaced = replaced_reg;

  // ****************************************
  // Pending request
  // ****************************************
  always @* begin
    pend_next = pend_reg;
    addr_next = addr_reg;
    size_next = size_reg;
    code_next = code_reg;
    pend_abort_next = pend_abort_reg;
    replaced_next = 1'b0;
    if (load) begin
      // A newer request overwrites one the far side has not taken
      pend_next = 1'b1;
      addr_next = req_addr;
      size_next = req_size;
      code_next = req_code;
      pend_abort_next = req_abort;
      replaced_next = pend_reg & ~accept;
    end else if (accept) begin
      // Lines keep their last values while idle
      pend_next = 1'b0;
      pend_abort_next = 1'b0;
    end
  end

  // ****************************************
  // Access in flight
  // ****************************************
  always @* begin
    busy_next = busy_reg;
    fl_size_next = fl_size_reg;
    fl_off_next = fl_off_reg;
    fl_abort_next = fl_abort_reg;
    abort_next = 1'b0;
    wait_next = wait_reg;
    if (accept) begin
      // Only one access tracked: the new one replaces the one just terminated
      busy_next = 1'b1;
      fl_size_next = size_reg;
      fl_off_next = addr_reg[1:0];
      fl_abort_next = pend_abort_reg;
      abort_next = pend_abort_reg;
      wait_next = {`CBMRP_WAIT_W{1'b0}};
    end else if (term) begin
      busy_next = 1'b0;
      fl_abort_next = 1'b0;
    end else if (busy_reg && wait_reg != `CBMRP_WAIT_MAX) begin
      wait_next = wait_reg + 1'b1;
    end
  end

  // ****************************************
  // Pending request registers
  // ****************************************
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg <= 1'b0;
      addr_reg <= `CBMRP_RST_ADDR;
      size_reg <= `CBMRP_RST_SIZE;
      code_reg <= `CBMRP_RST_CODE;
      pend_abort_reg <= 1'b0;
      replaced_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      addr_reg <= addr_next;
      size_reg <= size_next;
      code_reg <= code_next;
      pend_abort_reg <= pend_abort_next;
      replaced_reg <= replaced_next;
    end
  end

  // ****************************************
  // Access in flight registers
  // ****************************************
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      fl_size_reg <= `CBMRP_RST_SIZE;
      fl_off_reg <= 2'h0;
      fl_abort_reg <= 1'b0;
      abort_reg <= 1'b0;
      wait_reg <= {`CBMRP_WAIT_W{1'b0}};
    end else begin
      busy_reg <= busy_next;
      fl_size_reg <= fl_size_next;
      fl_off_reg <= fl_off_next;
      fl_abort_reg <= fl_abort_next;
      abort_reg <= abort_next;
      wait_reg <= wait_next;
    end
  end

  // ****************************************
  // Interrupt request sampling
  // ****************************************
  // Reset to the idle level so no false request follows reset
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b1;
      fast_irq_reg <= 1'b1;
    end else begin
      irq_reg <= irq_n;
      fast_irq_reg <= fast_irq_n;
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  cbmrp_lane_mux u_lane_mux (
    .xfer_size(fl_size_reg),
    .byte_offset(fl_off_reg),
    .bus_data(data_in),
    .operand(operand),
    .first_mux_byte()
  );

  // Data is taken only on a terminating edge; wait-state data is dropped
  assign rsp_word = {term_error, fl_abort_reg, wait_reg, operand};

  cbmrp_fifo #(
    .WIDTH(`CBMRP_RSP_W),
    .DEPTH(`CBMRP_FIFO_DEPTH),
    .AW(`CBMRP_FIFO_AW),
    .CW(`CBMRP_FIFO_CW)
  ) u_rsp_fifo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(term),
    .in_ready(fifo_in_ready),
    .in_data(rsp_word),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  assign rsp_error = fifo_out[41];
  assign rsp_aborted = fifo_out[40];
  assign rsp_wait = fifo_out[39:32];
  assign rsp_data = fifo_out[31:0];

  // ****************************************
  // Pin drive
  // ****************************************
  assign addr = addr_reg;
  assign xfer_size = size_reg;
  assign access_type_code = code_reg;
  assign read_write = 1'b1;
  assign xfer_request_n = ~pend_reg;
  assign access_in_flight = busy_reg;
  assign abort = abort_reg;
  // Read-only port: the data bus is never driven
  assign data_out = {`CBMRP_DATA_W{1'b0}};
  assign data_oe_n = 1'b1;
  assign irq_seen_n = irq_reg;
  assign fast_irq_seen_n = fast_irq_reg;

endmodule // cbmrp_read_port

`default_nettype wire

//--- test/cbmrp_mem_model.sv
// Memory interface model answering the read port.
// Assumes wait count and error choice come from the bench.
`timescale 1ns/1ps
`default_nettype none
`include "cbmrp_defines.vh"
module cbmrp_mem_model (
  input wire ref_clk,
  input wire arst_n,
  input wire [`CBMRP_ADDR_W-1:0] addr,
  input wire [`CBMRP_SIZE_W-1:0] xfer_size,
  input wire xfer_request_n,
  input wire access_in_flight,
  input wire abort,
  input wire [7:0] wait_cfg,
  input wire err_cfg,
  output logic xfer_done_n,
  output logic xfer_error_n,
  output logic [`CBMRP_DATA_W-1:0] data_in
);
  // ****
  // Responder
  // ****
  logic [22:0] a_q;
  logic [1:0] s_q;
  logic [7:0] cnt;
  logic [7:0] b [4];
  wire due = access_in_flight && cnt == wait_cfg;
  // Outputs derive from edge-updated state only, so they settle well before sampling
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
      a_q <= 23'h000000;
      s_q <= 2'h0;
    end else if (!xfer_request_n && (!access_in_flight || !xfer_done_n || !xfer_error_n)) begin
      a_q <= addr;
      s_q <= xfer_size;
      cnt <= 8'h00;
    end else if (access_in_flight) begin
      cnt <= cnt + 8'h01;
    end
  end
  always_comb begin
    for (int k = 0; k < 4; k++) b[k] = {a_q[7:2], 2'(k)};
    xfer_done_n = !(due && !err_cfg);
    xfer_error_n = !(abort || (due && err_cfg));
    // Unused lanes follow the wait counter, changing on each wait cycle, so a stale value never looks right
    data_in = {4{cnt ^ 8'h5A}};
    if (due) begin
      case (s_q)
        2'h1: data_in[7:0] = b[a_q[1:0]];
        2'h2: data_in[15:0] = {b[{a_q[1], 1'b0}], b[{a_q[1], 1'b1}]};
        default: data_in = {b[0], b[1], b[2], b[3]};
      endcase
    end
  end
endmodule // cbmrp_mem_model
`default_nettype wire

//--- test/cbmrp_read_port_monitor.sv
// Checker for the read port bus pins and response side.
// Assumes it is bound onto cbmrp_read_port, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cbmrp_monitor (
  input wire ref_clk,
  input wire arst_n,
  input wire rsp_valid,
  input wire rsp_error,
  input wire read_write,
  input wire data_oe_n,
  input wire xfer_request_n,
  input wire access_in_flight,
  input wire abort,
  input wire xfer_done_n,
  input wire xfer_error_n,
  input wire fast_irq_n,
  input wire fast_irq_seen_n
);
  // ****
  // Bus properties
  // ****
  wire term = access_in_flight && !(xfer_done_n && xfer_error_n);
  wire acc = !xfer_request_n && (!access_in_flight || term);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_accept; acc |=> access_in_flight; endproperty
  a_accept: assert property (p_accept) else $error("accepted access not in flight");
  property p_wait; access_in_flight && xfer_done_n && xfer_error_n |=> access_in_flight; endproperty
  a_wait: assert property (p_wait) else $error("access ended without termination");
  property p_end; term && xfer_request_n |=> !access_in_flight; endproperty
  a_end: assert property (p_end) else $error("access still in flight after end");
  property p_idle; !access_in_flight && xfer_request_n |=> !access_in_flight; endproperty
  a_idle: assert property (p_idle) else $error("access started without request");
  property p_abort; abort |-> $past(acc); endproperty
  a_abort: assert property (p_abort) else $error("abort not after acceptance");
  property p_rw; read_write && data_oe_n; endproperty
  a_rw: assert property (p_rw) else $error("read port drove write or data");
  property p_rsp; term |=> rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("no response after termination");
  property p_err; !rsp_valid && access_in_flight && !xfer_error_n |=> rsp_error; endproperty
  a_err: assert property (p_err) else $error("error termination not reported");
  property p_irq; fast_irq_seen_n == $past(fast_irq_n); endproperty
  a_irq: assert property (p_irq) else $error("fast request not sampled");
  c_b2b: cover property (acc && access_in_flight);
  c_abort: cover property (abort);
  c_wait: cover property ((access_in_flight && xfer_done_n && xfer_error_n) [*3]);
endmodule // cbmrp_monitor

bind cbmrp_read_port cbmrp_monitor u_mon (.ref_clk, .arst_n, .rsp_valid, .rsp_error, .read_write, .data_oe_n,
  .xfer_request_n, .access_in_flight, .abort, .xfer_done_n, .xfer_error_n, .fast_irq_n, .fast_irq_seen_n);
`default_nettype wire

//--- test/cbmrp_read_port_tb_top.sv
// Self-checking bench for the read port.
// Assumes the memory model on the bus pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module cbmrp_read_port_tb_top;
  // ****
  // Harness
  // ****
  logic ref_clk = 0, arst_n = 0, req_valid = 0, req_abort = 0, rsp_ready = 1, irq_n = 1, fast_irq_n = 1;
  logic err_cfg = 0, took = 0;
  logic [22:0] req_addr = 0;
  logic [1:0] req_size = 0;
  logic [2:0] req_code = 0;
  logic [7:0] wait_cfg = 0;
  wire req_ready, req_replaced, rsp_valid, rsp_error, rsp_aborted, data_oe_n, read_write, xfer_request_n;
  wire access_in_flight, abort, xfer_done_n, xfer_error_n, irq_seen_n, fast_irq_seen_n;
  wire [31:0] rsp_data, data_in, data_out;
  wire [22:0] addr;
  wire [1:0] xfer_size;
  wire [2:0] access_type_code;
  wire [7:0] rsp_wait;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  logic [41:0] q [$];
  cbmrp_read_port dut (.ref_clk, .arst_n, .req_valid, .req_ready, .req_addr, .req_size, .req_code, .req_abort,
    .req_replaced, .rsp_valid, .rsp_ready, .rsp_data, .rsp_error, .rsp_aborted, .rsp_wait, .addr, .data_in,
    .data_out, .data_oe_n, .xfer_size, .access_type_code, .read_write, .xfer_request_n, .access_in_flight,
    .abort, .xfer_done_n, .xfer_error_n, .irq_n, .fast_irq_n, .irq_seen_n, .fast_irq_seen_n);
  cbmrp_mem_model u_mem (.ref_clk, .arst_n, .addr, .xfer_size, .xfer_request_n, .access_in_flight, .abort,
    .wait_cfg, .err_cfg, .xfer_done_n, .xfer_error_n, .data_in);
  always #12.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (rsp_valid && rsp_ready) q.push_back({rsp_error, rsp_aborted, rsp_wait, rsp_data});
  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [41:0] seen, input logic [41:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function logic [31:0] expd(input logic [22:0] a, input logic [1:0] s);
    logic [7:0] b [4];
    for (int k = 0; k < 4; k++) b[k] = {a[7:2], 2'(k)};
    case (s)
      2'h1: expd = {24'h000000, b[a[1:0]]};
      2'h2: expd = {16'h0000, b[{a[1], 1'b0}], b[{a[1], 1'b1}]};
      default: expd = {b[0], b[1], b[2], b[3]};
    endcase
  endfunction
  // Called in a rising-edge step; returns at the edge that loads, or gives up after 20 cycles
  task send(input logic [22:0] a, input logic [1:0] s, input logic ab);
    req_valid <= 1;
    req_addr <= a;
    req_size <= s;
    req_code <= a[2:0];
    req_abort <= ab;
    for (int i = 0; i < 20; i++) begin
      @(negedge ref_clk);
      took = req_ready;
      if (took) break;
    end
    @(posedge ref_clk);
  endtask
  task pop(input string nm, input logic [41:0] exp, input logic [41:0] m);
    for (int i = 0; i < 100 && q.size() == 0; i++) @(posedge ref_clk);
    chk(nm, (q.size() ? q.pop_front() : {42{1'bx}}) & m, exp & m);
  endtask
  // ****
  // Scenarios
  // ****
  task t_reset;
    @(negedge ref_clk);
    chk("req_n", xfer_request_n, 1);
    chk("in_flight", access_in_flight, 0);
    chk("data_out", {data_oe_n, data_out}, 33'h100000000);
    @(posedge ref_clk);
  endtask
  task t_lanes;
    logic [22:0] a [7];
    logic [1:0] s [7];
    for (int i = 0; i < 7; i++) begin
      s[i] = i < 4 ? 2'h1 : (i < 6 ? 2'h2 : 2'h0);
      a[i] = 23'h000100 + 23'(i * 7);
      send(a[i], s[i], 0);
    end
    req_valid <= 0;
    for (int i = 0; i < 7; i++) pop("lanes", {10'h000, expd(a[i], s[i])}, {42{1'b1}});
  endtask
  task t_wait;
    wait_cfg <= 3;
    send(23'h000208, 0, 0);
    send(23'h00020C, 1, 0);
    send(23'h000212, 2, 0);
    req_valid <= 0;
    @(negedge ref_clk);
    chk("replaced", req_replaced, 1);
    chk("addr", addr, 23'h000212);
    chk("code", access_type_code, 3'h2);
    @(posedge ref_clk);
    pop("wait_a", {10'h003, expd(23'h000208, 0)}, {42{1'b1}});
    pop("wait_c", {10'h003, expd(23'h000212, 2)}, {42{1'b1}});
  endtask
  task t_err;
    wait_cfg <= 0;
    err_cfg <= 1;
    irq_n <= 0;
    fast_irq_n <= 0;
    send(23'h000400, 0, 0);
    req_valid <= 0;
    @(negedge ref_clk);
    chk("irq", irq_seen_n, 0);
    pop("error", 42'h20000000000, 42'h3FF00000000);
    err_cfg <= 0;
    irq_n <= 1;
    fast_irq_n <= 1;
  endtask
  task t_abort;
    wait_cfg <= 2;
    send(23'h000500, 1, 1);
    req_valid <= 0;
    pop("abort", 42'h30000000000, 42'h3FF00000000);
  endtask
  task t_fill;
    int n;
    rsp_ready <= 0;
    // No wait states: a request every cycle must never replace an unaccepted one here
    wait_cfg <= 0;
    for (n = 0; n < 8; n++) begin
      send(23'h000300 + 23'(4 * n), 0, 0);
      if (!took) break;
    end
    req_valid <= 0;
    rsp_ready <= 1;
    chk("refused", took, 0);
    for (int k = 0; k < n; k++) pop("drain", {10'h000, expd(23'h000300 + 23'(4 * k), 0)}, {42{1'b1}});
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1;
    @(posedge ref_clk);
    t_reset();
    t_lanes();
    t_wait();
    t_err();
    t_abort();
    t_fill();
    repeat (8) @(posedge ref_clk);
    chk("drained", q.size(), 0);
    give_verdict();
  end
endmodule // cbmrp_read_port_tb_top
`default_nettype wire
